// ### rtl/cehm_bank.sv
// Cache enable control and DRAM control memory hole register bank
//
// Decided for this implementation: the Wishbone slave port.
`default_nettype none
// Function
// - L1 enable set: indication asserted for cacheable processor cycles
// - L1 enable clear: indication negated, L1 and L2 line fills blocked
// - L1 enable and force miss set: L2 reads and writes are misses
// - L1 off, force miss on: L2 disabled, each read invalidates tag
// - L1 on, force miss off: normal L2 hit/miss per size select
// - DRAM control is 8-bit read/write at index 57h, resets to 01h
// - Processor cycles inside the selected hole go to PCI
// - PCI cycles inside the selected hole are not claimed, no DEVSEL#
// - DRAM under an enabled hole is not remapped, just unreachable
// - Hole select 00 means no hole, 01 means 512K to 640K
// - Force miss set with L1 on and L2 populated: every tag lookup reports a miss
module cehm_bank
  import cehm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [cehm_pkg::WB_ADR_W-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [cehm_pkg::WB_DAT_W-1:0] wbDatIn,
  output logic [cehm_pkg::WB_DAT_W-1:0] wbDatOut,
  output logic wbAck,
  input wire logic cpuCycValid,
  input wire logic [cehm_pkg::CPU_ADR_W-1:0] cpuAddr,
  input wire logic cpuWrite,
  input wire logic cpuCacheable,
  input wire logic tagMatch,
  output logic cpuRespValid,
  output logic cpuCacheableIndication,
  output logic cpuToPci,
  output logic cpuToDram,
  output logic l2Hit,
  output logic l2Miss,
  output logic l2TagInvalidate,
  output logic l1LineFillAllow,
  output logic l2LineFillAllow,
  input wire logic pciCycValid,
  input wire logic [cehm_pkg::CPU_ADR_W-1:0] pciAddr,
  output logic pciDevselClaim
);
  import cehm_pkg::*;

  typedef struct packed {
    logic [7:0] dramCtl;
    logic l1En;
    logic l2ForceMiss;
    logic [1:0] l2SizeSel;
    logic ack;
    logic [WB_DAT_W-1:0] rdData;
    logic respValid;
    logic ken;
    logic toPci;
    logic toDram;
    logic hit;
    logic miss;
    logic tagInval;
    logic l1Fill;
    logic l2Fill;
    logic pciClaim;
  } cehm_state_s;

  cehm_state_s stateReg;
  cehm_state_s stateNext;

  logic cpuInHole;
  logic pciInHole;
  logic [REG_IDX_W-1:0] wordIdx;
  logic busReq;
  logic wrTake;
  logic l2Populated;
  logic l2Enabled;
  logic [7:0] cacheCtlView;
  logic [7:0] statusView;
  logic [WB_DAT_W-1:0] readMux;

  ////////////////////////////////////////////////////////////////////////////
  // Hole decode, one decoder instance each for the processor and PCI address

  cehm_hole_match cpuHole (
    .addr(cpuAddr),
    .holeSel(stateReg.dramCtl[DC_HOLE_LSB +: 2]),
    .inHole(cpuInHole)
  );

  cehm_hole_match pciHole (
    .addr(pciAddr),
    .holeSel(stateReg.dramCtl[DC_HOLE_LSB +: 2]),
    .inHole(pciInHole)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register views

  assign wordIdx = wbAdr[WB_ADR_W-1:2];
  assign busReq = wbCyc & wbStb;
  // Write lands on the edge where the master sees ack
  assign wrTake = busReq & wbWe & stateReg.ack & wbSel[0];
  assign l2Populated = (stateReg.l2SizeSel != L2_SIZE_NONE);
  assign l2Enabled = stateReg.l1En & l2Populated;

  always_comb begin
    cacheCtlView = 8'h00;
    cacheCtlView[CC_L1_EN_BIT] = stateReg.l1En;
    cacheCtlView[CC_L2_FM_BIT] = stateReg.l2ForceMiss;
    cacheCtlView[CC_L2_SIZE_LSB +: 2] = stateReg.l2SizeSel;
  end

  always_comb begin
    statusView = 8'h00;
    statusView[ST_TO_PCI_BIT] = stateReg.toPci;
    statusView[ST_KEN_BIT] = stateReg.ken;
    statusView[ST_L2_HIT_BIT] = stateReg.hit;
    statusView[ST_PCI_CLAIM_BIT] = stateReg.pciClaim;
    statusView[ST_TAG_INVAL_BIT] = stateReg.tagInval;
  end

  always_comb begin
    case (wordIdx)
      REG_IDX_CACHE_CTL: begin
        readMux = {24'h000000, cacheCtlView};
      end
      REG_IDX_DRAM_CTL: begin
        readMux = {24'h000000, stateReg.dramCtl};
      end
      REG_IDX_STATUS: begin
        readMux = {24'h000000, statusView};
      end
      default: begin
        // Unmapped words read zero and still ack
        readMux = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    stateNext = stateReg;

    // Classic single-cycle ack, dropped the cycle after
    stateNext.ack = busReq & ~stateReg.ack;
    if (busReq & ~stateReg.ack) begin
      stateNext.rdData = readMux;
    end

    if (wrTake) begin
      case (wordIdx)
        REG_IDX_CACHE_CTL: begin
          stateNext.l1En = wbDatIn[CC_L1_EN_BIT];
          stateNext.l2ForceMiss = wbDatIn[CC_L2_FM_BIT];
          stateNext.l2SizeSel = wbDatIn[CC_L2_SIZE_LSB +: 2];
        end
        REG_IDX_DRAM_CTL: begin
          // Reserved bits 5:4 stay zero
          stateNext.dramCtl = wbDatIn[7:0] & DC_WRITE_MASK;
        end
        default: begin
          stateNext.dramCtl = stateReg.dramCtl;
        end
      endcase
    end

    // Processor cycle result, one cycle after the request
    stateNext.respValid = cpuCycValid;
    if (cpuCycValid) begin
      // Hole cycles leave DRAM alone; address is not remapped
      stateNext.toPci = cpuInHole;
      stateNext.toDram = ~cpuInHole;
      // Indication only for cacheable memory, never when L1 is off
      stateNext.ken = stateReg.l1En & cpuCacheable & ~cpuInHole;
      stateNext.l1Fill = stateReg.l1En & cpuCacheable & ~cpuInHole;
      stateNext.l2Fill = l2Enabled & ~stateReg.l2ForceMiss & cpuCacheable &
        ~cpuInHole & ~cpuWrite;
      // Force miss masks tag match on reads and writes alike
      stateNext.hit = l2Enabled & ~stateReg.l2ForceMiss & tagMatch &
        ~cpuInHole;
      stateNext.miss = l2Enabled & ~cpuInHole &
        (stateReg.l2ForceMiss | ~tagMatch);
      // Populated but disabled L2 with force miss: reads wipe the tag
      stateNext.tagInval = ~stateReg.l1En & stateReg.l2ForceMiss &
        l2Populated & ~cpuWrite & ~cpuInHole;
    end else begin
      stateNext.ken = 1'b0;
      stateNext.l1Fill = 1'b0;
      stateNext.l2Fill = 1'b0;
      stateNext.hit = 1'b0;
      stateNext.miss = 1'b0;
      stateNext.tagInval = 1'b0;
    end

    // PCI targets inside the hole are left for another agent
    stateNext.pciClaim = pciCycValid & ~pciInHole;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stateReg <= '0;
      stateReg.dramCtl <= DRAM_CTL_RESET;
      stateReg.l1En <= CACHE_CTL_RESET[CC_L1_EN_BIT];
      stateReg.l2ForceMiss <= CACHE_CTL_RESET[CC_L2_FM_BIT];
      stateReg.l2SizeSel <= CACHE_CTL_RESET[CC_L2_SIZE_LSB +: 2];
      stateReg.toDram <= 1'b1;
    end else begin
      stateReg <= stateNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wbAck = stateReg.ack;
  assign wbDatOut = stateReg.rdData;
  assign cpuRespValid = stateReg.respValid;
  assign cpuCacheableIndication = stateReg.ken;
  assign cpuToPci = stateReg.toPci;
  assign cpuToDram = stateReg.toDram;
  assign l2Hit = stateReg.hit;
  assign l2Miss = stateReg.miss;
  assign l2TagInvalidate = stateReg.tagInval;
  assign l1LineFillAllow = stateReg.l1Fill;
  assign l2LineFillAllow = stateReg.l2Fill;
  assign pciDevselClaim = stateReg.pciClaim;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  dramReset_a: assert property (
    @(posedge ref_clk) srst |=> (stateReg.dramCtl == 8'h01))
    else $error("dram control not 01h after reset");

  kenOff_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (cpuCycValid && !stateReg.l1En) |=>
      (!cpuCacheableIndication && !l1LineFillAllow && !l2LineFillAllow))
    else $error("cacheable indication or fill while L1 disabled");

  kenOn_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (cpuCycValid && stateReg.l1En && cpuCacheable && !cpuInHole) |=>
      (cpuCacheableIndication && cpuRespValid))
    else $error("cacheable indication missing");

  forceMiss_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (cpuCycValid && stateReg.l1En && stateReg.l2ForceMiss &&
      l2Populated && !cpuInHole) |=> (l2Miss && !l2Hit))
    else $error("forced miss reported as hit");

  tagInval_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (cpuCycValid && !stateReg.l1En && stateReg.l2ForceMiss &&
      l2Populated && !cpuWrite && !cpuInHole) |=>
      (l2TagInvalidate && !l2Hit && !l2Miss))
    else $error("tag invalidate missing on disabled L2 read");

  normalHit_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (cpuCycValid && l2Enabled && !stateReg.l2ForceMiss && !cpuInHole) |=>
      (l2Hit == $past(tagMatch)) && (l2Miss != l2Hit))
    else $error("normal hit processing wrong");

  l2Off_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (cpuCycValid && !stateReg.l1En && !stateReg.l2ForceMiss) |=>
      (!l2Hit && !l2Miss && !l2TagInvalidate))
    else $error("L2 active with both bits clear");

  holeRoute_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (cpuCycValid && stateReg.dramCtl[7:6] == 2'h1 &&
      cpuAddr >= 32'h0008_0000 && cpuAddr < 32'h000a_0000) |=>
      (cpuToPci && !cpuToDram))
    else $error("hole cycle not sent to PCI");

  pciIgnore_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (pciCycValid && stateReg.dramCtl[7:6] == 2'h1 &&
      pciAddr[31:17] == 15'h0004) |=> !pciDevselClaim)
    else $error("PCI cycle in hole claimed");

  noHole_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (stateReg.dramCtl[7:6] == 2'h0 && cpuCycValid) |=> cpuToDram)
    else $error("hole active with select 00");

  ackPulse_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// ### rtl/cehm_pkg.sv
// Package with register map, field layout and reset values of the bank
`default_nettype none
package cehm_pkg;
  // Wishbone geometry
  localparam int WB_ADR_W = 12;
  localparam int WB_DAT_W = 32;
  localparam int REG_IDX_W = 10;
  localparam int CPU_ADR_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [REG_IDX_W-1:0] REG_IDX_CACHE_CTL = 10'h050;
  localparam logic [REG_IDX_W-1:0] REG_IDX_DRAM_CTL = 10'h057;
  localparam logic [REG_IDX_W-1:0] REG_IDX_STATUS = 10'h058;

  // Reset values
  localparam logic [7:0] DRAM_CTL_RESET = 8'h01;
  localparam logic [7:0] CACHE_CTL_RESET = 8'h00;

  // Cache control field positions
  localparam int CC_L1_EN_BIT = 0;
  localparam int CC_L2_FM_BIT = 1;
  localparam int CC_L2_SIZE_LSB = 2;

  // DRAM control field positions and masks
  localparam int DC_HOLE_LSB = 6;
  localparam logic [7:0] DC_WRITE_MASK = 8'hcf;

  // Status field positions
  localparam int ST_TO_PCI_BIT = 0;
  localparam int ST_KEN_BIT = 1;
  localparam int ST_L2_HIT_BIT = 2;
  localparam int ST_PCI_CLAIM_BIT = 3;
  localparam int ST_TAG_INVAL_BIT = 4;

  // Hole select and L2 size encodings, hole bounds
  localparam logic [1:0] HOLE_NONE = 2'h0;
  localparam logic [1:0] HOLE_512K_640K = 2'h1;
  localparam logic [1:0] L2_SIZE_NONE = 2'h0;
  localparam logic [CPU_ADR_W-1:0] HOLE_LO_512K = 32'h0008_0000;
  localparam logic [CPU_ADR_W-1:0] HOLE_HI_640K = 32'h000a_0000;
endpackage
`default_nettype wire

// ### rtl/cehm_hole_match.sv
// Memory hole address decoder
`default_nettype none
module cehm_hole_match
  import cehm_pkg::*;
(
  input wire logic [cehm_pkg::CPU_ADR_W-1:0] addr,
  input wire logic [1:0] holeSel,
  output logic inHole
);
  always_comb begin
    case (holeSel)
      HOLE_512K_640K: begin
        // Half-open range, upper bound excluded
        inHole = (addr >= HOLE_LO_512K) && (addr < HOLE_HI_640K);
      end
      HOLE_NONE: begin
        inHole = 1'b0;
      end
      default: begin
        // Other encodings decode to no hole in this block
        inHole = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ### verif/cehm_far_model.sv
// Far-side model: processor bus and PCI master issuing single cycles
`default_nettype none
module cehm_far_model
  import cehm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [cehm_pkg::CPU_ADR_W-1:0] adr,
  input wire logic wr,
  input wire logic cach,
  input wire logic tag,
  output logic cpuCycValid,
  output logic [cehm_pkg::CPU_ADR_W-1:0] cpuAddr,
  output logic cpuWrite,
  output logic cpuCacheable,
  output logic tagMatch,
  output logic pciCycValid,
  output logic [cehm_pkg::CPU_ADR_W-1:0] pciAddr
);
  always @(posedge ref_clk) begin
    cpuCycValid <= go;
    pciCycValid <= go;
    if (go) begin
      cpuAddr <= adr;
      pciAddr <= adr;
      cpuWrite <= wr;
      cpuCacheable <= cach;
      tagMatch <= tag;
    end else begin
      // Idle qualifiers show the inverse, so stale ones never look valid
      cpuAddr <= ~adr;
      pciAddr <= ~adr;
      cpuWrite <= ~wr;
      cpuCacheable <= ~cach;
      tagMatch <= ~tag;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking testbench for the cache enable and memory hole bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cehm_pkg::*;
  logic ref_clk, srst, wbCyc, wbStb, wbWe, wbAck, go, wr, cach, tag;
  logic [11:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatIn, wbDatOut, adr, cpuAddr, pciAddr, rd;
  logic cpuCycValid, cpuWrite, cpuCacheable, tagMatch, pciCycValid;
  logic cpuRespValid, ken, cpuToPci, cpuToDram, l2Hit, l2Miss, inval;
  logic l1Fill, l2Fill, pciDevselClaim;
  int nMismatch = 0;
  int numChecks = 0;

  cehm_far_model far (.ref_clk(ref_clk), .go(go), .adr(adr), .wr(wr),
    .cach(cach), .tag(tag), .cpuCycValid(cpuCycValid), .cpuAddr(cpuAddr),
    .cpuWrite(cpuWrite), .cpuCacheable(cpuCacheable), .tagMatch(tagMatch),
    .pciCycValid(pciCycValid), .pciAddr(pciAddr));
  cehm_bank dut (.ref_clk(ref_clk), .srst(srst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .cpuCycValid(cpuCycValid), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
    .cpuCacheable(cpuCacheable), .tagMatch(tagMatch),
    .cpuRespValid(cpuRespValid), .cpuCacheableIndication(ken),
    .cpuToPci(cpuToPci), .cpuToDram(cpuToDram), .l2Hit(l2Hit),
    .l2Miss(l2Miss), .l2TagInvalidate(inval), .l1LineFillAllow(l1Fill),
    .l2LineFillAllow(l2Fill), .pciCycValid(pciCycValid),
    .pciAddr(pciAddr), .pciDevselClaim(pciDevselClaim));

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finishTest();
    if (nMismatch == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [11:0] a,
                    input logic [7:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= s;
    wbDatIn <= {24'h0, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (wbAck !== 1'b1) begin
      nMismatch++;
      finishTest();
    end else begin
      rd = wbDatOut;
    end
  endtask

  // One processor cycle and one PCI address phase, results sampled settled
  task automatic cyc(input logic [31:0] a, input logic w, c, t);
    @(posedge ref_clk);
    go <= 1'b1;
    adr <= a;
    wr <= w;
    cach <= c;
    tag <= t;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic reg_check();
    wb(1'b0, 12'h15c, 8'h00, 4'hf);
    chk(rd, 32'h01);
    wb(1'b0, 12'h140, 8'h00, 4'hf);
    chk(rd, 32'h00);
    wb(1'b1, 12'h15c, 8'hff, 4'hf);
    wb(1'b1, 12'h15c, 8'h00, 4'h0);
    wb(1'b0, 12'h15c, 8'h00, 4'hf);
    chk(rd, 32'hcf);
    wb(1'b1, 12'h3fc, 8'h5a, 4'hf);
    wb(1'b0, 12'h3fc, 8'h00, 4'hf);
    chk(rd, 32'h00);
    wb(1'b1, 12'h15c, 8'h01, 4'hf);
  endtask

  task automatic cache_mode_check();
    logic p, l1, fm, t, w, c, en, l2f, h, m, inv;
    for (int i = 0; i < 64; i++) begin
      {p, l1, fm, t, w, c} = i[5:0];
      // Size 00 leaves the L2 absent, 01 populates it
      en = l1 & p;
      l2f = en & ~fm & c & ~w;
      h = en & ~fm & t;
      m = en & (fm | ~t);
      inv = ~l1 & fm & p & ~w;
      wb(1'b1, 12'h140, {4'h0, 1'b0, p, fm, l1}, 4'h1);
      cyc(32'h0010_0000, w, c, t);
      chk({31'h0, cpuRespValid}, 32'h1);
      chk({30'h0, ken, l1Fill}, {30'h0, l1 & c, l1 & c});
      chk({30'h0, l2Fill, inval}, {30'h0, l2f, inv});
      chk({30'h0, l2Hit, l2Miss}, {30'h0, h, m});
    end
  endtask

  task automatic hole_check();
    logic [31:0] addrs [4] = '{32'h7ffff, 32'h80000, 32'h9ffff, 32'ha0000};
    logic inh;
    // L2 off before the hole field is touched
    wb(1'b1, 12'h140, 8'h00, 4'h1);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, 12'h15c, {s[1:0], 6'h01}, 4'h1);
      for (int k = 0; k < 4; k++) begin
        inh = (s == 1) && (k == 1 || k == 2);
        cyc(addrs[k], 1'b0, 1'b1, 1'b1);
        chk({29'h0, cpuToPci, cpuToDram, pciDevselClaim},
            {29'h0, inh, ~inh, ~inh});
      end
    end
    // Status keeps the routing of the last processor cycle
    wb(1'b1, 12'h15c, 8'h41, 4'h1);
    cyc(32'h0008_0000, 1'b0, 1'b1, 1'b1);
    wb(1'b0, 12'h160, 8'h00, 4'hf);
    chk(rd, 32'h01);
  endtask

  task automatic reset_check();
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk({29'h0, cpuToPci, cpuToDram, wbAck}, 32'h2);
    wb(1'b0, 12'h15c, 8'h00, 4'hf);
    chk(rd, 32'h01);
    wb(1'b0, 12'h140, 8'h00, 4'hf);
    chk(rd, 32'h00);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    {wbCyc, wbStb, wbWe, go, wr, cach, tag} = '0;
    wbAdr = '0;
    wbSel = '0;
    wbDatIn = '0;
    adr = '0;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    reg_check();
    cache_mode_check();
    hole_check();
    reset_check();
    finishTest();
  end
endmodule
`default_nettype wire
